// *** src/ipc_top.sv ***
// Interrupt priority controller with masking, pending flags and nesting
`timescale 1ns/10ps
module ipc_top
  import ipc_pkg::*;
(
  input  wire logic              clk_i,        // 50 MHz clock
  input  wire logic              rst_b_i,      // Async reset, active low
  input  wire logic              ext_irq_i,    // External line, rising edge
  input  wire logic              adc_evt_i,    // A/D event pulse
  input  wire logic [2:0]        pwm_evt_i,    // PWM/timer 0..2 event pulses
  input  wire ipc_pkg::ipc_vec_t enable_i,     // Per-source enable
  input  wire ipc_pkg::ipc_vec_t mask_i,       // Per-source mask, 1 blocks
  input  wire logic              rank_wr_i,    // Load priority ranks
  input  wire logic [7:0]        rank_data_i,  // Ranks of adc, pwm0..2
  input  wire ipc_pkg::ipc_vec_t clr_i,        // Clear pending pulses
  input  wire logic              ack_i,        // Processor takes request
  input  wire logic              eoi_i,        // Routine finished
  output logic                   irq_o,        // Request to processor
  output logic [2:0]             irq_id_o,     // Source of request
  output ipc_pkg::ipc_vec_t      pend_o,       // Pending flags
  output ipc_pkg::ipc_vec_t      insvc_o,      // Routines in service
  output logic [7:0]             rank_o        // Current ranks
);

  // ----------------------------------------------------------------
  // External line synchroniser and edge
  // ----------------------------------------------------------------
  logic [2:0] ext_sync;
  logic       ext_level;
  wire        ext_agree = (ext_sync[1] == ext_sync[2]);
  wire        ext_rise  = ext_agree && ext_sync[2] && !ext_level;

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      ext_sync  <= 3'h0;
      ext_level <= 1'b0;
    end else begin
      ext_sync  <= {ext_sync[1:0], ext_irq_i};
      if (ext_agree) begin
        ext_level <= ext_sync[2];
      end
    end
  end

  // ----------------------------------------------------------------
  // Decoding helpers
  // ----------------------------------------------------------------
  // One-hot vector that selects a single source
  function automatic ipc_vec_t src_bit(input logic [2:0] id);
    ipc_vec_t vec;
    vec = '0;
    for (int i = 0; i < NUM_SRC; i++) begin
      vec[i] = (id == 3'(i));
    end
    return vec;
  endfunction

  // Ranked sources sit below the fixed external key
  function automatic logic [2:0] rank_key(input logic [1:0] rank_fld);
    return KEY_RANK_BASE + {1'b0, rank_fld};
  endfunction

  // ----------------------------------------------------------------
  // Events, pending flags and in-service bits
  // ----------------------------------------------------------------
  ipc_vec_t   pend;
  ipc_vec_t   insvc;
  logic [7:0] rank;
  wire ipc_vec_t evt      = {pwm_evt_i, adc_evt_i, ext_rise};
  wire ipc_vec_t set_pend = evt & enable_i;

  // ----------------------------------------------------------------
  // Priority keys: external fixed at the top, others below it
  // ----------------------------------------------------------------
  wire ipc_keys_t keys;
  assign keys[2:0] = KEY_EXT;
  for (genvar g = 1; g < NUM_SRC; g++) begin : g_key
    assign keys[3*g +: 3] = rank_key(rank[2*(g-1) +: 2]);
  end

  // ----------------------------------------------------------------
  // Routine in service and processor handshake
  // ----------------------------------------------------------------
  logic       svc_any;
  logic [2:0] svc_id;

  ipc_arb u_svc_arb (
    .req_i  (insvc),
    .keys_i (keys),
    .any_o  (svc_any),
    .id_o   (svc_id),
    .key_o  ()
  );

  wire           take     = ack_i && irq_o;
  wire ipc_vec_t take_vec = take ? src_bit(irq_id_o) : '0;
  wire ipc_vec_t eoi_vec  = (eoi_i && svc_any) ? src_bit(svc_id) : '0;

  // Set wins over explicit clear and over acknowledge
  wire ipc_vec_t next_pend  = (pend & ~clr_i & ~take_vec) | set_pend;
  wire ipc_vec_t next_insvc = (insvc & ~eoi_vec) | take_vec;

  // ----------------------------------------------------------------
  // Request decision on the next state, so outputs track at once
  // ----------------------------------------------------------------
  logic       next_any;
  logic [2:0] next_id;
  logic [2:0] next_key;
  logic [2:0] next_svc_key;
  wire ipc_vec_t next_cand = next_pend & enable_i & ~mask_i;

  ipc_arb u_next_req_arb (
    .req_i  (next_cand),
    .keys_i (keys),
    .any_o  (next_any),
    .id_o   (next_id),
    .key_o  (next_key)
  );

  ipc_arb u_next_svc_arb (
    .req_i  (next_insvc),
    .keys_i (keys),
    .any_o  (),
    .id_o   (),
    .key_o  (next_svc_key)
  );

  // Only a strictly better key interrupts the routine in service
  wire next_irq = next_any && (next_key < next_svc_key);

  // ----------------------------------------------------------------
  // State registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      pend  <= '0;
      insvc <= '0;
    end else begin
      pend  <= next_pend;
      insvc <= next_insvc;
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rank <= RANK_RST;
    end else if (rank_wr_i) begin
      rank <= rank_data_i;
    end
  end

  // ----------------------------------------------------------------
  // Registered outputs
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      irq_o    <= 1'b0;
      irq_id_o <= SRC_EXT;
    end else begin
      irq_o    <= next_irq;
      irq_id_o <= next_id;
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      pend_o  <= '0;
      insvc_o <= '0;
    end else begin
      pend_o  <= next_pend;
      insvc_o <= next_insvc;
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rank_o <= RANK_RST;
    end else if (rank_wr_i) begin
      rank_o <= rank_data_i;
    end
  end

endmodule // ipc_top

// *** src/ipc_pkg.sv ***
// Constants and types shared by the interrupt priority controller
package ipc_pkg;

  // ----------------------------------------------------------------
  // Sources
  // ----------------------------------------------------------------
  localparam int unsigned NUM_SRC = 5;
  localparam logic [2:0]  SRC_EXT  = 3'h0;
  localparam logic [2:0]  SRC_ADC  = 3'h1;
  localparam logic [2:0]  SRC_PWM0 = 3'h2;
  localparam logic [2:0]  SRC_PWM1 = 3'h3;
  localparam logic [2:0]  SRC_PWM2 = 3'h4;

  // ----------------------------------------------------------------
  // Priority keys: lower key wins
  // ----------------------------------------------------------------
  localparam logic [2:0]  KEY_EXT  = 3'h0;
  localparam logic [2:0]  KEY_IDLE = 3'h7;
  localparam logic [2:0]  KEY_RANK_BASE = 3'h1;
  // Ranks of adc [1:0], pwm0 [3:2], pwm1 [5:4], pwm2 [7:6]
  localparam logic [7:0]  RANK_RST = 8'h93;
  localparam logic [4:0]  ENABLE_RST = 5'h00;
  localparam logic [4:0]  MASK_RST   = 5'h00;

  typedef logic [NUM_SRC-1:0]   ipc_vec_t;
  typedef logic [3*NUM_SRC-1:0] ipc_keys_t;

endpackage

// *** src/ipc_arb.sv ***
// Fixed-key selector: lowest key wins, ties go to the lower index
`timescale 1ns/10ps
module ipc_arb
  import ipc_pkg::*;
(
  input  wire ipc_pkg::ipc_vec_t  req_i,   // Candidate sources
  input  wire ipc_pkg::ipc_keys_t keys_i,  // Three-bit key per source
  output logic                    any_o,   // Some candidate present
  output logic [2:0]              id_o,    // Winning source
  output logic [2:0]              key_o    // Winning key, idle when none
);

  always_comb begin
    any_o = 1'b0;
    id_o  = 3'h0;
    key_o = KEY_IDLE;
    for (int i = 0; i < NUM_SRC; i++) begin
      if (req_i[i] && (keys_i[3*i +: 3] < key_o || !any_o)) begin
        any_o = 1'b1;
        id_o  = 3'(i);
        key_o = keys_i[3*i +: 3];
      end
    end
  end

endmodule // ipc_arb

// *** tb/ipc_cpu_model.sv ***
// Processor core model: takes requests, tracks its stack
`timescale 1ns/10ps
module ipc_cpu_model (
  input  wire logic clk_i,   // Clock
  input  wire logic rst_b_i, // Reset
  input  wire logic irq_i,   // Request
  input  wire logic take_i,  // Core may take
  input  wire logic eoi_i,   // Routine ends
  output logic       ack_o,  // Take pulse
  output logic [7:0] sp_o    // Stack pointer, grows down
);
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      ack_o <= 1'b0;
      sp_o  <= 8'h80;
    end else begin
      ack_o <= irq_i && take_i && !ack_o;
      if (ack_o && irq_i) sp_o <= sp_o - 8'h02;
      else if (eoi_i) sp_o <= sp_o + 8'h02;
    end
  end
endmodule // ipc_cpu_model

// *** tb/ipc_top_monitor.sv ***
// Port assertions for the interrupt controller
`timescale 1ns/10ps
module ipc_monitor
  import ipc_pkg::*;
(
  input wire logic              clk_i,       // Clock
  input wire logic              rst_b_i,     // Reset
  input wire logic [2:0]        pwm_evt_i,   // Timers
  input wire logic              adc_evt_i,   // A/D
  input wire ipc_pkg::ipc_vec_t enable_i,    // Enables
  input wire ipc_pkg::ipc_vec_t mask_i,      // Masks
  input wire logic              rank_wr_i,   // Load
  input wire logic [7:0]        rank_data_i, // Ranks in
  input wire ipc_pkg::ipc_vec_t clr_i,       // Clears
  input wire logic              ack_i,       // Take
  input wire logic              irq_o,       // Request
  input wire logic [2:0]        irq_id_o,    // Source
  input wire ipc_pkg::ipc_vec_t pend_o,      // Pending
  input wire ipc_pkg::ipc_vec_t insvc_o,     // Serving
  input wire logic [7:0]        rank_o       // Ranks
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);
  sequence take_s; ack_i && irq_o; endsequence
  sequence served_s; !pend_o[$past(irq_id_o)] && insvc_o[$past(irq_id_o)]; endsequence
  rst_state_a: assert property ($rose(rst_b_i) |-> rank_o == RANK_RST && !irq_o)
    else $error("Bad reset state");
  drop_evt_a: assert property (!enable_i[2] && pwm_evt_i[0] && !pend_o[2] |=> !pend_o[2])
    else $error("Disabled event latched");
  evt_latch_a: assert property (enable_i[3] && pwm_evt_i[1] |=> pend_o[3])
    else $error("Event lost");
  clr_flag_a: assert property (clr_i[4] && !pwm_evt_i[2] |=> !pend_o[4])
    else $error("Clear ignored");
  mask_blk_a: assert property (irq_o && $stable(mask_i) |-> !mask_i[irq_id_o])
    else $error("Masked source sent");
  ext_top_a: assert property (irq_o && pend_o[0] && enable_i[0] && !mask_i[0]
    && $stable(mask_i) && $stable(enable_i) && !insvc_o[0] |-> irq_id_o == SRC_EXT)
    else $error("External outranked");
  no_nest_a: assert property (insvc_o[0] |-> !irq_o)
    else $error("Nested over external");
  take_req_a: assert property (take_s |=> served_s)
    else $error("Take not applied");
  rank_ld_a: assert property (rank_wr_i |=> rank_o == $past(rank_data_i))
    else $error("Rank load failed");
endmodule // ipc_monitor
bind ipc_top ipc_monitor u_mon (
  .clk_i       (clk_i),
  .rst_b_i     (rst_b_i),
  .pwm_evt_i   (pwm_evt_i),
  .adc_evt_i   (adc_evt_i),
  .enable_i    (enable_i),
  .mask_i      (mask_i),
  .rank_wr_i   (rank_wr_i),
  .rank_data_i (rank_data_i),
  .clr_i       (clr_i),
  .ack_i       (ack_i),
  .irq_o       (irq_o),
  .irq_id_o    (irq_id_o),
  .pend_o      (pend_o),
  .insvc_o     (insvc_o),
  .rank_o      (rank_o)
);

// *** tb/interrupt_priority_controller_tb_top.sv ***
// Self-checking bench for the interrupt controller
`timescale 1ns/10ps
module interrupt_priority_controller_tb_top;
  import ipc_pkg::*;
  logic       clk = 0, rst_b = 0, ext = 0, adc = 0, rwr = 0, eoi = 0, take = 0;
  logic [2:0] pwm = 0, id;
  logic [7:0] rdat = 0, rank, sp;
  ipc_vec_t   en = 0, msk = 0, clr = 0, pend, insvc;
  logic       irq, ack;
  int         n_fail = 0, check_count = 0, cyc = 0;
  ipc_top u_dut (.clk_i(clk), .rst_b_i(rst_b), .ext_irq_i(ext), .adc_evt_i(adc),
    .pwm_evt_i(pwm), .enable_i(en), .mask_i(msk), .rank_wr_i(rwr), .rank_data_i(rdat),
    .clr_i(clr), .ack_i(ack), .eoi_i(eoi), .irq_o(irq), .irq_id_o(id), .pend_o(pend),
    .insvc_o(insvc), .rank_o(rank));
  ipc_cpu_model u_cpu (.clk_i(clk), .rst_b_i(rst_b), .irq_i(irq), .take_i(take),
    .eoi_i(eoi), .ack_o(ack), .sp_o(sp));
  always #10 clk = ~clk;
  task automatic print_verdict();
    if (n_fail == 0 && check_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      n_fail++;
      print_verdict();
    end
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic take_one();
    @(posedge clk) take <= 1;
    repeat (2) @(posedge clk);
    take <= 0;
    @(negedge clk);
  endtask
  task automatic t_reset();
    @(posedge clk) pwm <= 3'h1;
    @(posedge clk) pwm <= 3'h0;
    @(negedge clk);
    chk(rank, RANK_RST);
    chk(8'(pend), 8'h00);
    chk(8'(irq), 8'h00);
  endtask
  task automatic t_order();
    logic [2:0] ids [4] = '{3'h2, 3'h3, 3'h4, 3'h1};
    @(posedge clk) begin en <= 5'h1F; adc <= 1; pwm <= 3'h7; end
    @(posedge clk) begin adc <= 0; pwm <= 3'h0; end
    @(negedge clk) chk(8'(pend), 8'h1E);
    foreach (ids[i]) begin
      chk(8'(id), 8'(ids[i]));
      take_one();
      chk(8'(insvc), 8'h01 << ids[i]);
      @(posedge clk) eoi <= 1;
      @(posedge clk) eoi <= 0;
      @(negedge clk);
    end
  endtask
  task automatic t_mask();
    @(posedge clk) begin msk <= 5'h1F; pwm <= 3'h4; end
    @(posedge clk) pwm <= 3'h0;
    @(negedge clk) chk(8'(irq), 8'h00);
    chk(8'(pend), 8'h10);
    @(posedge clk) begin clr <= 5'h10; msk <= 5'h00; end
    @(posedge clk) clr <= 5'h00;
    @(negedge clk) chk(8'(pend), 8'h00);
  endtask
  task automatic t_nest();
    @(posedge clk) begin rwr <= 1; rdat <= 8'h1B; end
    @(posedge clk) begin rwr <= 0; pwm <= 3'h7; end
    @(posedge clk) pwm <= 3'h0;
    @(negedge clk) chk(8'(id), 8'h04);
    take_one();
    @(posedge clk) ext <= 1;
    repeat (4) @(posedge clk);
    @(negedge clk) chk(8'(id), 8'h00);
    take_one();
    chk(8'(insvc), 8'h11);
    chk(sp, 8'h7C);
    @(posedge clk) eoi <= 1;
    @(posedge clk) eoi <= 0;
    @(negedge clk) chk(8'(insvc), 8'h10);
    chk(8'(irq), 8'h00);
    chk(sp, 8'h7E);
  endtask
  initial begin
    repeat (2) @(posedge clk);
    rst_b <= 1;
    t_reset();
    t_order();
    t_mask();
    t_nest();
    print_verdict();
  end
endmodule // interrupt_priority_controller_tb_top
